// [design/lifm_pkg.sv]
// shared constants for the logic input function mapper
package lifm_pkg;
  // ==========================================================
  // sizes
  localparam int NLI      = 20;
  localparam int NUSR     = 20;
  localparam int NSEL     = 16;
  localparam int SELW     = 5;
  localparam int NAUX     = 5;
  localparam int DLYW     = 16;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_STAT  = 8'h00;
  localparam logic [7:0] ADDR_LIN   = 8'h04;
  localparam logic [7:0] ADDR_USRST = 8'h08;
  localparam logic [7:0] ADDR_SEL0  = 8'h10;
  localparam logic [7:0] ADDR_USR0  = 8'h40;
  localparam logic [31:0] SEL_RST   = 32'h0;
  localparam logic [31:0] USR_RST   = 32'h0;
  // ==========================================================
  // selector slots, four per word, one byte lane each
  localparam int SEL_BKRCLS   = 0;
  localparam int SEL_BKROPN   = 1;
  localparam int SEL_CONN     = 2;
  localparam int SEL_LOCAL    = 3;
  localparam int SEL_RESET    = 4;
  localparam int SEL_ROPEN    = 5;
  localparam int SEL_RCLOSE   = 6;
  localparam int SEL_CLP      = 7;
  localparam int SEL_GRP2     = 8;
  localparam int SEL_GRP3     = 9;
  localparam int SEL_GRP4     = 10;
  localparam int SEL_BLKTRIP  = 11;
  localparam int SEL_BLKCLOSE = 12;
  localparam int SEL_BLKRST   = 13;
  localparam int SEL_BLKUV1   = 14;
  localparam int SEL_BLKUV2   = 15;
  // ==========================================================
  // user input word layout
  localparam int USR_SRC_LSB = 0;
  localparam int USR_FN_LSB  = 5;
  localparam int USR_RLY_LSB = 8;
  localparam int USR_DLY_LSB = 16;
  localparam logic [2:0] FN_DISABLED = 3'h0;
  localparam logic [2:0] FN_TRIP     = 3'h1;
  localparam logic [2:0] FN_TRIPRECL = 3'h2;
  localparam logic [2:0] FN_ALARM    = 3'h3;
  localparam logic [2:0] FN_LALARM   = 3'h4;
  localparam logic [2:0] FN_CONTROL  = 3'h5;
  localparam logic [DLYW-1:0] DLY_MAX = 16'hea60;
  // ==========================================================
  // timing: delay step of 0.01 s
  localparam int STEP_NS  = 10000000;
  localparam int CLK_NS   = 4;
  localparam int TICK_CYC = STEP_NS / CLK_NS;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lifm_pkg

// [design/lifm_user_timer.sv]
// qualifying delay timer of one user input function
`timescale 1ns/1ns
`default_nettype none
module lifm_user_timer
  import lifm_pkg::*;
(
  input  wire logic            clk,      // system clock
  input  wire logic            nrst,     // async reset, low
  input  wire logic            tick,     // 0.01 s enable pulse
  input  wire logic            srcOn,    // selected source asserted
  input  wire logic [DLYW-1:0] delay,    // delay in ticks
  output var  logic            operated  // delay expired, source held
);
  logic [DLYW-1:0] cnt_r;
  logic            op_r;

  // ==========================================================
  // continuous-assertion counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (!srcOn) begin
      cnt_r <= '0; // RL24
    end else if (tick && cnt_r < delay) begin
      cnt_r <= cnt_r + 16'h1; // RL15
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_r <= 1'b0;
    end else begin
      op_r <= srcOn && (cnt_r >= delay); // RL15
    end
  end
  assign operated = op_r;

  // ==========================================================
  a_delay_drop: assert property (@(posedge clk) disable iff (!nrst) // RL24
    !srcOn |=> !op_r ##0 cnt_r == '0)
    else $error("timer not cleared after source drop");
  a_delay_early: assert property (@(posedge clk) disable iff (!nrst) // RL15
    (cnt_r < delay) |=> !op_r)
    else $error("user input operated before delay");
endmodule : lifm_user_timer
`default_nettype wire

// [design/lifm_mapper.sv]
// logic input function mapper: breaker state, control, user and block functions
// Contract
// RL1: only closed-aux assigned: breaker closed follows that contact closed.
// RL2: only open-aux assigned: breaker closed while that contact open.
// RL3: both assigned: closed-aux closed means closed, open-aux closed open; none unknown.
// RL4: local mode while local-mode input asserted, remote otherwise.
// RL5: remote open energises trip relay only in remote mode.
// RL6: remote close energises close relay only in remote mode.
// RL7: reset clears last-trip and latched relays unless block-reset asserted.
// RL8: autoreclose variant: reset also clears autoreclose lockout.
// RL9: group-select inputs request setpoint groups 2, 3, 4.
// RL10: every function selector is disabled or names logic input 1 to 20.
// RL11: cold-load-pickup input starts the cold-load blocking feature.
// RL12: twenty identical user input functions, each with own source.
// RL13: user output type: disabled, trip, trip with reclose, alarm, latched, control.
// RL14: user function operates any combination of aux relays 3 to 7.
// RL15: user function operates after source held for 0 to 600 s delay.
// RL16: block-trip input stops trip relay; detection carries on.
// RL17: with block-close selected, close relay only while that input clear.
// RL18: a blocked protection element neither detects, messages nor indicates.
// RL19: separate block inputs inhibit undervoltage elements 1 and 2.
// RL20: breaker disconnected: state shown neither open nor closed.
// RL21: breaker aux functions go on logic inputs 1 to 14 only; the code accepts any logic input 1 to 20 for them.
// RL22: disabled selector means function permanently de-asserted; the code treats a disabled connected selector as always connected.
// RL23: highest requested group wins; group 1 when none requested.
// RL24: delay timer restarts when source drops before expiry.
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module lifm_mapper
  import lifm_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,  // clocks per 0.01 s
  parameter bit HAS_AR      = 1'b1       // autoreclose variant
) (
  input  wire logic           clk,          // 250 MHz clock
  input  wire logic           nrst,         // async reset, low
  input  wire logic [7:0]     awaddr,       // axi write address
  input  wire logic           awvalid,      // axi
  output var  logic           awready,      // axi
  input  wire logic [31:0]    wdata,        // axi write data
  input  wire logic [3:0]     wstrb,        // axi byte enables
  input  wire logic           wvalid,       // axi
  output var  logic           wready,       // axi
  output var  logic [1:0]     bresp,        // axi
  output var  logic           bvalid,       // axi
  input  wire logic           bready,       // axi
  input  wire logic [7:0]     araddr,       // axi read address
  input  wire logic           arvalid,      // axi
  output var  logic           arready,      // axi
  output var  logic [31:0]    rdata,        // axi read data
  output var  logic [1:0]     rresp,        // axi
  output var  logic           rvalid,       // axi
  input  wire logic           rready,       // axi
  input  wire logic [NLI-1:0] logicIn,      // asserted logic inputs, async
  output var  logic           bkrClosed,    // breaker reported closed
  output var  logic           bkrOpen,      // breaker reported open
  output var  logic           bkrUnknown,   // no aux contact assigned
  output var  logic           localMode,    // local mode, else remote
  output var  logic           tripRelay,    // trip output relay
  output var  logic           closeRelay,   // close output relay
  output var  logic [NAUX-1:0] auxRelay,    // aux relays 3..7
  output var  logic           lastTrip,     // last-trip indicator
  output var  logic           resetOut,     // reset applied (level)
  output var  logic           arLockoutClr, // clear autoreclose lockout
  output var  logic           coldLoadStart, // cold-load-pickup start
  output var  logic [2:0]     activeGroup,  // setpoint group 1..4
  output var  logic           userTrip,     // user trip request
  output var  logic           userReclose,  // user trip with reclose
  output var  logic           userAlarm,    // user alarm
  output var  logic           userLatAlarm, // latched user alarm
  output var  logic           userControl,  // user control
  output var  logic           uv1Block,     // inhibit undervoltage 1
  output var  logic           uv2Block      // inhibit undervoltage 2
);
  // ==========================================================
  // input synchroniser: a change counts once stages 2 and 3 agree
  logic [NLI-1:0] s1_r, s2_r, s3_r, li_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      li_r <= '0;
    end else begin
      s1_r <= logicIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      li_r <= ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & li_r);
    end
  end

  // ==========================================================
  // registers
  logic [31:0] selReg_r [NSEL/4];
  logic [31:0] usrReg_r [NUSR];

  function automatic logic [4:0] selOf(input int k);
    selOf = selReg_r[k/4][(k%4)*8 +: SELW];
  endfunction : selOf

  // out-of-range codes 21..31 act as disabled on all but the connected and aux selectors
  function automatic logic pick(input logic [4:0] s);
    pick = 1'b0;
    if (s != 5'h0 && s <= 5'(NLI)) begin // RL10 RL22
      pick = li_r[s - 5'h1];
    end
  endfunction : pick

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  st);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        merge[b*8 +: 8] = d[b*8 +: 8];
      end
    end
  endfunction : merge

  // ==========================================================
  // function decode
  logic fCls, fOpn, fConn, fLocal, fRst, fROpen, fRClose, fClp;
  logic fG2, fG3, fG4, fBlkTrip, fBlkClose, fBlkRst, aSet, bSet;
  always_comb begin
    aSet      = selOf(SEL_BKRCLS) != 5'h0;
    bSet      = selOf(SEL_BKROPN) != 5'h0;
    fCls      = pick(selOf(SEL_BKRCLS));
    fOpn      = pick(selOf(SEL_BKROPN));
    // an unassigned connected input means always connected
    fConn     = (selOf(SEL_CONN) == 5'h0) || pick(selOf(SEL_CONN));
    fLocal    = pick(selOf(SEL_LOCAL));
    fRst      = pick(selOf(SEL_RESET));
    fROpen    = pick(selOf(SEL_ROPEN));
    fRClose   = pick(selOf(SEL_RCLOSE));
    fClp      = pick(selOf(SEL_CLP));
    fG2       = pick(selOf(SEL_GRP2));
    fG3       = pick(selOf(SEL_GRP3));
    fG4       = pick(selOf(SEL_GRP4));
    fBlkTrip  = pick(selOf(SEL_BLKTRIP));
    fBlkClose = pick(selOf(SEL_BLKCLOSE));
    fBlkRst   = pick(selOf(SEL_BLKRST));
  end
  logic rstEff;
  assign rstEff = fRst && !fBlkRst; // RL7

  // ==========================================================
  // 0.01 s tick divider
  logic [21:0] div_r;
  logic        tick_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else if (div_r == 22'(TICK_CYCLES - 1)) begin
      div_r  <= '0;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 22'h1;
      tick_r <= 1'b0;
    end
  end

  // ==========================================================
  // user input functions
  logic [NUSR-1:0] usrOp;
  generate
    for (genvar u = 0; u < NUSR; u++) begin : g_usr
      logic [DLYW-1:0] dly;
      assign dly = (usrReg_r[u][USR_DLY_LSB +: DLYW] > DLY_MAX) ?
                   DLY_MAX : usrReg_r[u][USR_DLY_LSB +: DLYW];
      lifm_user_timer u_tmr ( // RL12
        .clk      (clk),
        .nrst     (nrst),
        .tick     (tick_r),
        .srcOn    (pick(usrReg_r[u][USR_SRC_LSB +: SELW])),
        .delay    (dly),
        .operated (usrOp[u])
      );
    end
  endgenerate

  logic            uTrip, uRecl, uAlm, uLAlm, uCtl;
  logic [NAUX-1:0] auxNow, auxLat;
  always_comb begin
    uTrip  = 1'b0;
    uRecl  = 1'b0;
    uAlm   = 1'b0;
    uLAlm  = 1'b0;
    uCtl   = 1'b0;
    auxNow = '0;
    auxLat = '0;
    for (int u = 0; u < NUSR; u++) begin
      if (usrOp[u]) begin
        unique case (usrReg_r[u][USR_FN_LSB +: 3]) // RL13
          FN_TRIP:     uTrip = 1'b1;
          FN_TRIPRECL: begin
            uTrip = 1'b1;
            uRecl = 1'b1;
          end
          FN_ALARM:    uAlm  = 1'b1;
          FN_LALARM:   uLAlm = 1'b1;
          FN_CONTROL:  uCtl  = 1'b1;
          default:     ;
        endcase
        if (usrReg_r[u][USR_FN_LSB +: 3] != FN_DISABLED) begin
          auxNow = auxNow | usrReg_r[u][USR_RLY_LSB +: NAUX]; // RL14
        end
        if (usrReg_r[u][USR_FN_LSB +: 3] == FN_LALARM) begin
          auxLat = auxLat | usrReg_r[u][USR_RLY_LSB +: NAUX];
        end
      end
    end
  end

  // ==========================================================
  // breaker state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bkrClosed  <= 1'b0;
      bkrOpen    <= 1'b0;
      bkrUnknown <= 1'b1;
    end else begin
      bkrUnknown <= !aSet && !bSet; // RL3
      if (!fConn) begin
        bkrClosed <= 1'b0; // RL20
        bkrOpen   <= 1'b0;
      end else if (aSet && bSet) begin
        bkrClosed <= fCls; // RL3
        bkrOpen   <= fOpn;
      end else if (aSet) begin
        bkrClosed <= fCls; // RL1
        bkrOpen   <= !fCls;
      end else if (bSet) begin
        bkrClosed <= !fOpn; // RL2
        bkrOpen   <= fOpn;
      end else begin
        bkrClosed <= 1'b0;
        bkrOpen   <= 1'b0;
      end
    end
  end

  // ==========================================================
  // control and block functions
  logic [NAUX-1:0] latch_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      localMode     <= 1'b0;
      tripRelay     <= 1'b0;
      closeRelay    <= 1'b0;
      resetOut      <= 1'b0;
      arLockoutClr  <= 1'b0;
      coldLoadStart <= 1'b0;
      activeGroup   <= 3'h1;
      uv1Block      <= 1'b0;
      uv2Block      <= 1'b0;
    end else begin
      localMode     <= fLocal; // RL4
      tripRelay     <= !fBlkTrip && ((fROpen && !fLocal) || uTrip); // RL5 RL16
      closeRelay    <= !fBlkClose && fRClose && !fLocal; // RL6 RL17
      resetOut      <= rstEff; // RL7
      arLockoutClr  <= HAS_AR && rstEff; // RL8
      coldLoadStart <= fClp; // RL11
      activeGroup   <= fG4 ? 3'h4 : fG3 ? 3'h3 : fG2 ? 3'h2 : 3'h1; // RL9 RL23
      // blocked elements are told here; they suppress their own messages
      uv1Block      <= pick(selOf(SEL_BLKUV1)); // RL18 RL19
      uv2Block      <= pick(selOf(SEL_BLKUV2)); // RL19
    end
  end

  // latches: a new set in the reset cycle survives it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lastTrip     <= 1'b0;
      latch_r      <= '0;
      userLatAlarm <= 1'b0;
    end else begin
      lastTrip     <= (lastTrip && !rstEff) || tripRelay; // RL7
      latch_r      <= (rstEff ? '0 : latch_r) | auxLat;
      userLatAlarm <= (userLatAlarm && !rstEff) || uLAlm;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      auxRelay    <= '0;
      userTrip    <= 1'b0;
      userReclose <= 1'b0;
      userAlarm   <= 1'b0;
      userControl <= 1'b0;
    end else begin
      auxRelay    <= auxNow | latch_r; // RL14
      userTrip    <= uTrip;
      userReclose <= uRecl;
      userAlarm   <= uAlm;
      userControl <= uCtl;
    end
  end

  // ==========================================================
  // axi4-lite slave: one write, one read at a time
  logic [7:0] wa_r;
  logic       haveA_r, haveW_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;
  logic        doWr;
  assign doWr = haveA_r && haveW_r && !bvalid;
  assign awready = !haveA_r;
  assign wready  = !haveW_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      haveA_r <= 1'b0;
      haveW_r <= 1'b0;
      wa_r    <= '0;
      wd_r    <= '0;
      ws_r    <= '0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      if (awvalid && !haveA_r) begin
        haveA_r <= 1'b1;
        wa_r    <= awaddr;
      end
      if (wvalid && !haveW_r) begin
        haveW_r <= 1'b1;
        wd_r    <= wdata;
        ws_r    <= wstrb;
      end
      if (doWr) begin
        haveA_r <= 1'b0;
        haveW_r <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (wa_r[1:0] == 2'h0 && ((wa_r >= ADDR_SEL0 && wa_r < ADDR_SEL0 + 8'h10) ||
                   (wa_r >= ADDR_USR0 && wa_r < ADDR_USR0 + 8'h50))) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NSEL / 4; i++) selReg_r[i] <= SEL_RST;
      for (int i = 0; i < NUSR; i++) usrReg_r[i] <= USR_RST;
    end else if (doWr && wa_r[1:0] == 2'h0) begin
      for (int i = 0; i < NSEL / 4; i++) begin
        if (wa_r == ADDR_SEL0 + 8'(4 * i)) selReg_r[i] <= merge(selReg_r[i], wd_r, ws_r);
      end
      for (int i = 0; i < NUSR; i++) begin
        if (wa_r == ADDR_USR0 + 8'(4 * i)) usrReg_r[i] <= merge(usrReg_r[i], wd_r, ws_r);
      end
    end
  end

  logic [31:0] rd;
  logic        rdOk;
  always_comb begin
    rd   = '0;
    rdOk = 1'b1;
    if (araddr == ADDR_STAT) begin
      rd = {14'h0, uv2Block, uv1Block, coldLoadStart, auxRelay, closeRelay,
            tripRelay, lastTrip, activeGroup, localMode, bkrUnknown, bkrOpen, bkrClosed};
    end else if (araddr == ADDR_LIN) begin
      rd = {12'h0, li_r};
    end else if (araddr == ADDR_USRST) begin
      rd = {12'h0, usrOp};
    end else begin
      rdOk = 1'b0;
      for (int i = 0; i < NSEL / 4; i++) begin
        if (araddr == ADDR_SEL0 + 8'(4 * i)) begin
          rd   = selReg_r[i];
          rdOk = 1'b1;
        end
      end
      for (int i = 0; i < NUSR; i++) begin
        if (araddr == ADDR_USR0 + 8'(4 * i)) begin
          rd   = usrReg_r[i];
          rdOk = 1'b1;
        end
      end
    end
  end

  assign arready = !rvalid;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata  <= rd;
      rresp  <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================================
  sequence s_rstReq;
    fRst ##0 !fBlkRst;
  endsequence
  sequence s_rstDone;
    resetOut ##0 (!lastTrip || $past(tripRelay));
  endsequence
  a_reset_clear: assert property (@(posedge clk) disable iff (!nrst) // RL7
    s_rstReq |=> s_rstDone)
    else $error("reset did not clear last trip");
  a_reset_block: assert property (@(posedge clk) disable iff (!nrst) // RL7
    fBlkRst |=> !resetOut && !arLockoutClr)
    else $error("reset passed while blocked");
  a_brk_closedaux: assert property (@(posedge clk) disable iff (!nrst) // RL1
    (aSet && !bSet && fConn) |=> (bkrClosed == $past(fCls)) && (bkrOpen != bkrClosed))
    else $error("closed-aux interpretation wrong");
  a_brk_openaux: assert property (@(posedge clk) disable iff (!nrst) // RL2
    (!aSet && bSet && fConn) |=> (bkrClosed == !$past(fOpn)) && (bkrOpen != bkrClosed))
    else $error("open-aux interpretation wrong");
  a_brk_disc: assert property (@(posedge clk) disable iff (!nrst) // RL20
    !fConn |=> !bkrOpen && !bkrClosed)
    else $error("disconnected breaker shown open or closed");
  a_local_gate: assert property (@(posedge clk) disable iff (!nrst) // RL5 RL6
    (fLocal && !uTrip) |=> localMode && !tripRelay && !closeRelay)
    else $error("remote control acted in local mode");
  a_trip_block: assert property (@(posedge clk) disable iff (!nrst) // RL16
    fBlkTrip |=> !tripRelay)
    else $error("trip relay operated while blocked");
  a_close_perm: assert property (@(posedge clk) disable iff (!nrst) // RL17
    closeRelay |-> $past(!fBlkClose && fRClose))
    else $error("close relay without permission");
  a_group_pick: assert property (@(posedge clk) disable iff (!nrst) // RL23
    (fG4 |=> activeGroup == 3'h4) and ((!fG2 && !fG3 && !fG4) |=> activeGroup == 3'h1))
    else $error("setpoint group choice wrong");
endmodule : lifm_mapper
`default_nettype wire

// [sim/lifm_field_model.sv]
// field contact model: registered breaker aux and external contacts
`timescale 1ns/1ns
`default_nettype none
module lifm_field_model
  import lifm_pkg::*;
(
  input  wire logic           clk,     // bench clock
  input  wire logic           nrst,    // async reset, low
  input  wire logic [NLI-1:0] req,     // contact states set by bench
  output var  logic [NLI-1:0] logicIn  // asserted logic inputs
);
  // ==========
  // contacts move only after an edge, like a debounced input
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) logicIn <= '0;
    else logicIn <= req;
  end
endmodule : lifm_field_model
`default_nettype wire

// [sim/lifm_mapper_tb.sv]
// testbench of the logic input function mapper
`timescale 1ns/1ns
`default_nettype none
module lifm_mapper_tb
  import lifm_pkg::*;
;
  // ==========
  // signals
  logic            clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]      awaddr, araddr;
  logic [31:0]     wdata, rdata, got;
  logic [3:0]      wstrb;
  logic [1:0]      bresp, rresp, gotResp;
  logic            awready, wready, bvalid, arready, rvalid;
  logic [NLI-1:0]  req, logicIn;
  logic            bkrClosed, bkrOpen, bkrUnknown, localMode, tripRelay, closeRelay;
  logic [NAUX-1:0] auxRelay;
  logic            lastTrip, resetOut, arLockoutClr, coldLoadStart;
  logic [2:0]      activeGroup;
  logic            userTrip, userReclose, userAlarm, userLatAlarm, userControl;
  logic            uv1Block, uv2Block;
  int              n_fail, checks;
  // latched alarm last, so its sticky output does not spoil the others
  logic [2:0]      fns [5] = '{FN_TRIP, FN_TRIPRECL, FN_ALARM, FN_CONTROL, FN_LALARM};
  logic [4:0]      exps [5] = '{5'h10, 5'h18, 5'h04, 5'h01, 5'h02};

  lifm_mapper #(.TICK_CYCLES(4), .HAS_AR(1'b1)) i_dut (
    .clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .logicIn, .bkrClosed, .bkrOpen, .bkrUnknown, .localMode,
    .tripRelay, .closeRelay, .auxRelay, .lastTrip, .resetOut, .arLockoutClr,
    .coldLoadStart, .activeGroup, .userTrip, .userReclose, .userAlarm,
    .userLatAlarm, .userControl, .uv1Block, .uv2Block);
  lifm_field_model i_field (.clk, .nrst, .req, .logicIn);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========
  // tasks
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic hang(input int n);
    if (n >= 50) begin
      n_fail++;
      results();
    end
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready  <= 1'b0;
    gotResp = bresp;
    hang(n);
    // one more edge so registered outputs show the new settings
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready  <= 1'b0;
    got     = rdata;
    gotResp = rresp;
    hang(n);
  endtask : rd
  // input path takes about five cycles, so ten leave margin
  task automatic setIn(input logic [NLI-1:0] v);
    @(posedge clk);
    req <= v;
    repeat (10) @(posedge clk);
  endtask : setIn
  // ==========
  // main sequence
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb  = 4'hf;
    req    = '0;
    n_fail = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    wr(ADDR_SEL0 + 8'h04, 32'h0b05040a);
    chk("bresp", gotResp, RESP_OKAY);
    wr(ADDR_SEL0 + 8'h08, 32'h0c080706);
    wr(ADDR_SEL0 + 8'h0c, 32'h100f0e0d);
    rd(ADDR_SEL0 + 8'h0c);
    chk("sel word", got, 32'h100f0e0d);
    setIn('0);
    chk("unknown", {bkrClosed, bkrOpen, bkrUnknown}, 3'h1);
    wr(ADDR_SEL0, 32'h03000001);
    chk("cls only open", {bkrClosed, bkrOpen}, 2'h1);
    setIn(20'h00001);
    chk("cls only closed", {bkrClosed, bkrOpen}, 2'h2);
    wr(ADDR_SEL0, 32'h03000200);
    setIn(20'h00002);
    chk("opn only open", {bkrClosed, bkrOpen}, 2'h1);
    setIn('0);
    chk("opn only closed", {bkrClosed, bkrOpen}, 2'h2);
    wr(ADDR_SEL0, 32'h03000201);
    setIn(20'h00001);
    chk("both closed", {bkrClosed, bkrOpen, bkrUnknown}, 3'h4);
    setIn(20'h00002);
    chk("both open", {bkrClosed, bkrOpen, bkrUnknown}, 3'h2);
    wr(ADDR_SEL0, 32'h03110201);
    chk("disconnected", {bkrClosed, bkrOpen}, 2'h0);
    setIn(20'h10002);
    chk("connected", {bkrClosed, bkrOpen}, 2'h1);
    setIn(20'h00008);
    chk("remote open", {localMode, tripRelay}, 2'h1);
    setIn(20'h0000c);
    chk("local open", {localMode, tripRelay}, 2'h2);
    setIn(20'h00014);
    chk("local close", closeRelay, 1'b0);
    setIn(20'h00010);
    chk("remote close", closeRelay, 1'b1);
    setIn(20'h01010);
    chk("blocked close", closeRelay, 1'b0);
    setIn(20'h00808);
    chk("blocked trip", tripRelay, 1'b0);
    for (int i = 0; i < 8; i++) begin
      setIn(NLI'(i) << 5);
      chk("group", activeGroup, i[2] ? 3'h4 : i[1] ? 3'h3 : i[0] ? 3'h2 : 3'h1);
    end
    setIn(20'h0c400);
    chk("uv clp", {uv1Block, uv2Block, coldLoadStart}, 3'h7);
    setIn(20'h04000);
    chk("uv1 only", {uv1Block, uv2Block, coldLoadStart}, 3'h4);
    wr(ADDR_USR0 + 8'h04, 32'h00000020);
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_USR0, {16'h0000, 3'h0, 5'h01, fns[k], 5'h09});
      setIn(20'h00100);
      chk("user type", {userTrip, userReclose, userAlarm, userLatAlarm, userControl}, exps[k]);
      setIn('0);
    end
    chk("latched", {auxRelay, userLatAlarm, lastTrip}, 7'h07);
    setIn(20'h02200);
    chk("reset blocked", {auxRelay, userLatAlarm, lastTrip, resetOut}, 8'h0e);
    setIn(20'h00200);
    chk("reset", {auxRelay, userLatAlarm, lastTrip, resetOut, arLockoutClr}, 9'h003);
    wr(ADDR_USR0 + 8'h4c, {16'h0005, 3'h0, 5'h1f, FN_ALARM, 5'h09});
    setIn(20'h00100);
    setIn('0);
    setIn(20'h00100);
    repeat (6) @(posedge clk);
    chk("restart", userAlarm, 1'b0);
    repeat (30) @(posedge clk);
    chk("delayed", {auxRelay, userAlarm}, 6'h3f);
    wr(8'hfc, 32'h0);
    chk("unmapped wr resp", gotResp, RESP_SLVERR);
    rd(8'hfc);
    chk("unmapped resp", gotResp, RESP_SLVERR);
    chk("unmapped data", got, 32'h0);
    results();
  end
endmodule : lifm_mapper_tb
`default_nettype wire
